// >>> uim_map.svh
// register map, field positions, reset values and code constants
`ifndef UIM_MAP_SVH
`define UIM_MAP_SVH

`define UIM_OFS_DEV_ADDR 8'h08
`define UIM_OFS_FUNC_SEL 8'h0C
`define UIM_OFS_OTG_CTRL 8'h10
`define UIM_OFS_OTG_STAT 8'h14
`define UIM_OFS_SERIAL 8'h18
`define UIM_OFS_FLAGS 8'h1C
`define UIM_OFS_HOLD_SEL 8'h20
`define UIM_OFS_OUT_MASKS 8'h24
`define UIM_OFS_FRAME 8'h28
`define UIM_OFS_PID 8'h2C
`define UIM_OFS_EP_SEEN 8'h30
`define UIM_OFS_EP_MASK 8'h34

`define UIM_FS_OPMODE_HI 4
`define UIM_FS_OPMODE_LO 2
`define UIM_FS_TERM 1
`define UIM_FS_XCVR 0
`define UIM_FS_RESET 5'h07

`define UIM_OTG_EXTIND 7
`define UIM_OTG_DRVEXT 6
`define UIM_OTG_CHRG 4
`define UIM_OTG_DISCHRG 3
`define UIM_OTG_DMPD 2
`define UIM_OTG_DPPD 1
`define UIM_OTG_IDPU 0
`define UIM_OTG_WMASK 8'hDF
`define UIM_OTG_RESET 8'h00

`define UIM_SER_RX_LO 4
`define UIM_SER_TXSE0 3
`define UIM_SER_TXDATA 2
`define UIM_SER_TXEN_N 1
`define UIM_SER_FSLS 0
`define UIM_SER_RESET 4'h2

`define UIM_FLAG_TOK 6
`define UIM_FLAG_SE0 5
`define UIM_FLAG_K 4
`define UIM_FLAG_J 3
`define UIM_FLAG_CRC16 2
`define UIM_FLAG_RXACT 1
`define UIM_FLAG_RXERR 0
`define UIM_FLAG_LEVEL 7'h03

`define UIM_MASK_C_LO 16
`define UIM_MASK_B_LO 8
`define UIM_MASK_A_LO 0
`define UIM_FRAME_HI_LO 8
`define UIM_EP_VALID 4
`define UIM_EP_SPECIAL 8'h10

`define UIM_LS_SE0 2'h0
`define UIM_LS_J 2'h1
`define UIM_LS_K 2'h2

`define UIM_CRC5_INIT 5'h1F
`define UIM_CRC5_POLY 5'h05
`define UIM_CRC5_RES 5'h0C
`define UIM_CRC16_INIT 16'hFFFF
`define UIM_CRC16_POLY 16'h8005
`define UIM_CRC16_RES 16'h800D
`define UIM_PID_SOF 4'h5
`define UIM_PID_TOKEN 2'h1
`define UIM_PID_DATA 2'h3

`endif

// >>> uim_pkg.sv
// types shared by the usb interface module files
package uim_pkg;
  typedef enum logic [2:0] {
    UIM_ST_IDLE = 3'h1,
    UIM_ST_PID = 3'h2,
    UIM_ST_BODY = 3'h4
  } uim_dec_state_t;
endpackage

// >>> uim_pkt_decoder.sv
// receive packet decoder: pid check, token fields, crc5 and crc16
`timescale 1ns/1ns
`include "uim_map.svh"
module uim_pkt_decoder
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic rx_active_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic [6:0] dev_addr_i,
  output logic pkt_start_o,
  output logic pid_valid_o,
  output logic [3:0] pid_o,
  output logic tok_done_o,
  output logic tok_ok_o,
  output logic [3:0] tok_ep_o,
  output logic sof_valid_o,
  output logic [10:0] frame_o,
  output logic crc_err_o,
  output logic data_valid_o,
  output logic [7:0] data_byte_o
);
  // usb sends each byte lsb first
  function automatic logic [4:0] uim_crc5_byte(input logic [4:0] c,
                                               input logic [7:0] d);
    logic [4:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[4] ^ d[i])
        r = {r[3:0], 1'b0} ^ `UIM_CRC5_POLY;
      else
        r = {r[3:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [15:0] uim_crc16_byte(input logic [15:0] c,
                                                 input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[15] ^ d[i])
        r = {r[14:0], 1'b0} ^ `UIM_CRC16_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction

  uim_pkg::uim_dec_state_t state_reg, state_next;
  logic [3:0] pid_reg, pid_next;
  logic pid_ok_reg, pid_ok_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [7:0] b1_reg, b1_next;
  logic [4:0] crc5_reg, crc5_next;
  logic [15:0] crc16_reg, crc16_next;
  logic [3:0] ep_reg, ep_next;
  logic [10:0] frame_reg, frame_next;
  logic amatch_reg, amatch_next;
  logic start_reg, start_next;
  logic pidv_reg, pidv_next;
  logic tdone_reg, tdone_next;
  logic tok_reg, tok_next;
  logic sof_reg, sof_next;
  logic cerr_reg, cerr_next;
  logic dv_reg, dv_next;
  logic [7:0] db_reg, db_next;
  logic is_tok;
  logic is_data;

  always_comb
  begin
    state_next = state_reg;
    pid_next = pid_reg;
    pid_ok_next = pid_ok_reg;
    cnt_next = cnt_reg;
    b1_next = b1_reg;
    crc5_next = crc5_reg;
    crc16_next = crc16_reg;
    ep_next = ep_reg;
    frame_next = frame_reg;
    amatch_next = amatch_reg;
    start_next = 1'b0;
    pidv_next = 1'b0;
    tdone_next = 1'b0;
    tok_next = 1'b0;
    sof_next = 1'b0;
    cerr_next = 1'b0;
    dv_next = 1'b0;
    db_next = db_reg;
    is_tok = pid_ok_reg && pid_reg[1:0] == `UIM_PID_TOKEN &&
             pid_reg != `UIM_PID_SOF;
    is_data = pid_ok_reg && pid_reg[1:0] == `UIM_PID_DATA;
    case (state_reg)
      uim_pkg::UIM_ST_IDLE:
      begin
        if (rx_active_i)
        begin
          state_next = uim_pkg::UIM_ST_PID;
          start_next = 1'b1;
          cnt_next = 2'h0;
          crc5_next = `UIM_CRC5_INIT;
          crc16_next = `UIM_CRC16_INIT;
        end
      end
      uim_pkg::UIM_ST_PID:
      begin
        if (!rx_active_i)
          state_next = uim_pkg::UIM_ST_IDLE;
        else if (rx_valid_i)
        begin
          state_next = uim_pkg::UIM_ST_BODY;
          pid_next = rx_data_i[3:0];
          pid_ok_next = rx_data_i[3:0] == ~rx_data_i[7:4];
          pidv_next = 1'b1;
        end
      end
      uim_pkg::UIM_ST_BODY:
      begin
        if (!rx_active_i)
        begin
          state_next = uim_pkg::UIM_ST_IDLE;
          tdone_next = is_tok;
          tok_next = is_tok && cnt_reg == 2'h2 &&
                     crc5_reg == `UIM_CRC5_RES && amatch_reg;
          sof_next = pid_ok_reg && pid_reg == `UIM_PID_SOF &&
                     cnt_reg == 2'h2 && crc5_reg == `UIM_CRC5_RES;
          cerr_next = is_data &&
                      (!cnt_reg[1] || crc16_reg != `UIM_CRC16_RES);
        end
        else if (rx_valid_i)
        begin
          crc5_next = uim_crc5_byte(crc5_reg, rx_data_i);
          crc16_next = uim_crc16_byte(crc16_reg, rx_data_i);
          if (cnt_reg != 2'h3)
            cnt_next = cnt_reg + 2'h1;
          if (cnt_reg == 2'h0)
            b1_next = rx_data_i;
          if (cnt_reg == 2'h1)
          begin
            ep_next = {rx_data_i[2:0], b1_reg[7]};
            frame_next = {rx_data_i[2:0], b1_reg};
            amatch_next = b1_reg[6:0] == dev_addr_i;
          end
          dv_next = is_data;
          db_next = rx_data_i;
        end
      end
      default:
        state_next = uim_pkg::UIM_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= uim_pkg::UIM_ST_IDLE;
      pid_reg <= 4'h0;
      pid_ok_reg <= 1'b0;
      cnt_reg <= 2'h0;
      b1_reg <= 8'h00;
      crc5_reg <= `UIM_CRC5_INIT;
      crc16_reg <= `UIM_CRC16_INIT;
      ep_reg <= 4'h0;
      frame_reg <= 11'h000;
      amatch_reg <= 1'b0;
      start_reg <= 1'b0;
      pidv_reg <= 1'b0;
      tdone_reg <= 1'b0;
      tok_reg <= 1'b0;
      sof_reg <= 1'b0;
      cerr_reg <= 1'b0;
      dv_reg <= 1'b0;
      db_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      pid_reg <= pid_next;
      pid_ok_reg <= pid_ok_next;
      cnt_reg <= cnt_next;
      b1_reg <= b1_next;
      crc5_reg <= crc5_next;
      crc16_reg <= crc16_next;
      ep_reg <= ep_next;
      frame_reg <= frame_next;
      amatch_reg <= amatch_next;
      start_reg <= start_next;
      pidv_reg <= pidv_next;
      tdone_reg <= tdone_next;
      tok_reg <= tok_next;
      sof_reg <= sof_next;
      cerr_reg <= cerr_next;
      dv_reg <= dv_next;
      db_reg <= db_next;
    end
  end

  assign pkt_start_o = start_reg;
  assign pid_valid_o = pidv_reg;
  assign pid_o = pid_reg;
  assign tok_done_o = tdone_reg;
  assign tok_ok_o = tok_reg;
  assign tok_ep_o = ep_reg;
  assign sof_valid_o = sof_reg;
  assign frame_o = frame_reg;
  assign crc_err_o = cerr_reg;
  assign data_valid_o = dv_reg;
  assign data_byte_o = db_reg;
endmodule

// >>> uim_core.sv
// usb interface module: utmi+ control, line event flags and registers
// How it works
// - opmode output comes from function select bits 4:2, reset one
// - termination select bit 1, transceiver select bit 0, both reset one
// - otg control bits drive vbus, charge, pulldown and id pullup outputs
// - otg status register shows live bvalid, idgnd, disconnect, session inputs
// - serial control reads receive data, d-minus, d-plus levels at 6:4
// - serial control drives tx se0, tx data, tx enable low, serial mode
// - non-sticky flags clear when the next packet starts; sticky ones hold
// - flag 6 sets on a good token addressed to this device
// - flags 5, 4, 3 set on se0, k and j line states
// - flag 2 sets when a data packet fails its crc16
// - flags 1 and 0 follow receive active and receive error
// - hold select makes a flag sticky until a one is written to it
// - three masks each or selected flags onto one flag output
// - eleven bit frame number, read-write, split 10:8 and 7:0
// - last received packet identifier kept in a read-only field
// - last endpoint kept in bits 3:0 with a valid bit at 4
// - endpoints marked special reach the receive port ored with 0x10
// - only packets for the stored device address are passed on
`timescale 1ns/1ns
`include "uim_map.svh"
module uim_core
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic [2:0] utmi_opmode_o,
  output logic utmi_termselect_o,
  output logic utmi_xcvrselect_o,
  output logic ext_vbus_indicator_mode_o,
  output logic drive_vbus_external_mode_o,
  output logic utmi_chrgvbus_o,
  output logic utmi_dischrgvbus_o,
  output logic utmi_dmpulldown_o,
  output logic utmi_dppulldown_o,
  output logic utmi_idpullup_o,
  input wire logic utmi_bvalid_i,
  input wire logic utmi_idgnd_i,
  input wire logic utmi_hostdisconnect_i,
  input wire logic utmi_vbusvalid_i,
  input wire logic utmi_sessvld_i,
  input wire logic utmi_sessend_i,
  input wire logic utmi_rx_rcv_i,
  input wire logic utmi_rx_dm_i,
  input wire logic utmi_rx_dp_i,
  output logic utmi_tx_se0_o,
  output logic utmi_tx_data_o,
  output logic utmi_tx_enable_n_o,
  output logic utmi_fsls_serial_o,
  input wire logic [1:0] utmi_linestate_i,
  input wire logic utmi_rxactive_i,
  input wire logic utmi_rxvalid_i,
  input wire logic utmi_rxerror_i,
  input wire logic [7:0] utmi_data_i,
  output logic flag_out_a_o,
  output logic flag_out_b_o,
  output logic flag_out_c_o,
  output logic [7:0] rx_byte_o,
  output logic rx_byte_valid_o
);
  logic [6:0] dev_addr_reg, dev_addr_next;
  logic [4:0] func_reg, func_next;
  logic [7:0] otg_reg, otg_next;
  logic [3:0] ser_reg, ser_next;
  logic [2:0] ser_rx_reg, ser_rx_next;
  logic [6:0] flags_reg, flags_next;
  logic [6:0] hold_reg, hold_next;
  logic [6:0] mask_a_reg, mask_a_next;
  logic [6:0] mask_b_reg, mask_b_next;
  logic [6:0] mask_c_reg, mask_c_next;
  logic [10:0] frame_reg, frame_next;
  logic [3:0] pid_reg, pid_next;
  logic [4:0] ep_reg, ep_next;
  logic [15:0] ep_mask_reg, ep_mask_next;
  logic [2:0] fout_reg, fout_next;
  logic armed_reg, armed_next;
  logic [7:0] rxb_reg, rxb_next;
  logic rxv_reg, rxv_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [6:0] ev;
  logic [6:0] clr;
  logic [6:0] hold_mask;
  logic pkt_start;
  logic pid_valid;
  logic [3:0] dec_pid;
  logic tok_done;
  logic tok_ok;
  logic [3:0] tok_ep;
  logic sof_valid;
  logic [10:0] dec_frame;
  logic crc_err;
  logic data_valid;
  logic [7:0] data_byte;

  uim_pkt_decoder u_dec
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .rx_active_i(utmi_rxactive_i),
    .rx_valid_i(utmi_rxvalid_i),
    .rx_data_i(utmi_data_i),
    .dev_addr_i(dev_addr_reg),
    .pkt_start_o(pkt_start),
    .pid_valid_o(pid_valid),
    .pid_o(dec_pid),
    .tok_done_o(tok_done),
    .tok_ok_o(tok_ok),
    .tok_ep_o(tok_ep),
    .sof_valid_o(sof_valid),
    .frame_o(dec_frame),
    .crc_err_o(crc_err),
    .data_valid_o(data_valid),
    .data_byte_o(data_byte)
  );

  always_comb
  begin
    dev_addr_next = dev_addr_reg;
    func_next = func_reg;
    otg_next = otg_reg;
    ser_next = ser_reg;
    hold_next = hold_reg;
    mask_a_next = mask_a_reg;
    mask_b_next = mask_b_reg;
    mask_c_next = mask_c_reg;
    frame_next = frame_reg;
    ep_mask_next = ep_mask_reg;
    clr = 7'h00;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `UIM_OFS_DEV_ADDR: dev_addr_next = reg_wdata_i[6:0];
        `UIM_OFS_FUNC_SEL: func_next = reg_wdata_i[4:0];
        // bit 5 is reserved, so the write mask drops it
        `UIM_OFS_OTG_CTRL:
          otg_next = reg_wdata_i[7:0] & `UIM_OTG_WMASK;
        `UIM_OFS_SERIAL: ser_next = reg_wdata_i[3:0];
        `UIM_OFS_FLAGS: clr = reg_wdata_i[6:0];
        `UIM_OFS_HOLD_SEL: hold_next = reg_wdata_i[6:0];
        `UIM_OFS_OUT_MASKS:
        begin
          mask_a_next = reg_wdata_i[`UIM_MASK_A_LO+:7];
          mask_b_next = reg_wdata_i[`UIM_MASK_B_LO+:7];
          mask_c_next = reg_wdata_i[`UIM_MASK_C_LO+:7];
        end
        `UIM_OFS_FRAME: frame_next = reg_wdata_i[10:0];
        `UIM_OFS_EP_MASK: ep_mask_next = reg_wdata_i[15:0];
        default: ;
      endcase
    end
    // a frame number received on the wire beats a same-cycle write
    if (sof_valid)
      frame_next = dec_frame;
  end

  always_comb
  begin
    // line-state flags re-set every cycle the state persists
    ev = 7'h00;
    ev[`UIM_FLAG_TOK] = tok_ok;
    ev[`UIM_FLAG_SE0] = utmi_linestate_i == `UIM_LS_SE0;
    ev[`UIM_FLAG_K] = utmi_linestate_i == `UIM_LS_K;
    ev[`UIM_FLAG_J] = utmi_linestate_i == `UIM_LS_J;
    ev[`UIM_FLAG_CRC16] = crc_err;
    ev[`UIM_FLAG_RXACT] = utmi_rxactive_i;
    ev[`UIM_FLAG_RXERR] = utmi_rxerror_i;
    // non-sticky level flags track the input; new events beat clears
    hold_mask = ~clr & ~(~hold_reg & {7{pkt_start}}) &
                ~(~hold_reg & `UIM_FLAG_LEVEL);
    flags_next = ev | (flags_reg & hold_mask);
    fout_next[0] = |(flags_next & mask_a_reg);
    fout_next[1] = |(flags_next & mask_b_reg);
    fout_next[2] = |(flags_next & mask_c_reg);
    // receive levels pass one register stage before software sees them
    ser_rx_next = {utmi_rx_rcv_i, utmi_rx_dm_i, utmi_rx_dp_i};
    // pid is kept even for packets addressed elsewhere
    pid_next = pid_valid ? dec_pid : pid_reg;
    ep_next = tok_ok ? {1'b1, tok_ep} : ep_reg;
    // a data packet follows only a token that matched our address
    armed_next = tok_ok ? 1'b1 : (tok_done ? 1'b0 : armed_reg);
    rxv_next = tok_ok || (data_valid && armed_reg);
    rxb_next = rxb_reg;
    if (tok_ok)
      rxb_next = {4'h0, tok_ep} |
                 (ep_mask_reg[tok_ep] ? `UIM_EP_SPECIAL : 8'h00);
    else if (data_valid && armed_reg)
      rxb_next = data_byte;
  end

  // read data is registered so it lines up with the valid pulse;
  // unmapped addresses still answer, with zero data
  always_comb
  begin
    rvalid_next = reg_rd_i;
    rdata_next = 32'h00000000;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `UIM_OFS_DEV_ADDR: rdata_next[6:0] = dev_addr_reg;
        `UIM_OFS_FUNC_SEL: rdata_next[4:0] = func_reg;
        `UIM_OFS_OTG_CTRL: rdata_next[7:0] = otg_reg;
        `UIM_OFS_OTG_STAT:
          rdata_next[5:0] = {utmi_bvalid_i, utmi_idgnd_i,
                             utmi_hostdisconnect_i, utmi_vbusvalid_i,
                             utmi_sessvld_i, utmi_sessend_i};
        `UIM_OFS_SERIAL: rdata_next[6:0] = {ser_rx_reg, ser_reg};
        `UIM_OFS_FLAGS: rdata_next[6:0] = flags_reg;
        `UIM_OFS_HOLD_SEL: rdata_next[6:0] = hold_reg;
        `UIM_OFS_OUT_MASKS:
        begin
          rdata_next[`UIM_MASK_A_LO+:7] = mask_a_reg;
          rdata_next[`UIM_MASK_B_LO+:7] = mask_b_reg;
          rdata_next[`UIM_MASK_C_LO+:7] = mask_c_reg;
        end
        `UIM_OFS_FRAME: rdata_next[10:0] = frame_reg;
        `UIM_OFS_PID: rdata_next[3:0] = pid_reg;
        `UIM_OFS_EP_SEEN: rdata_next[4:0] = ep_reg;
        `UIM_OFS_EP_MASK: rdata_next[15:0] = ep_mask_reg;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // no clock needed: every register takes its reset value as soon as reset falls
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dev_addr_reg <= 7'h00;
      func_reg <= `UIM_FS_RESET;
      otg_reg <= `UIM_OTG_RESET;
      ser_reg <= `UIM_SER_RESET;
      ser_rx_reg <= 3'h0;
      flags_reg <= 7'h00;
      hold_reg <= 7'h00;
      mask_a_reg <= 7'h00;
      mask_b_reg <= 7'h00;
      mask_c_reg <= 7'h00;
      frame_reg <= 11'h000;
      pid_reg <= 4'h0;
      ep_reg <= 5'h00;
      ep_mask_reg <= 16'h0000;
      fout_reg <= 3'h0;
      armed_reg <= 1'b0;
      rxb_reg <= 8'h00;
      rxv_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      dev_addr_reg <= dev_addr_next;
      func_reg <= func_next;
      otg_reg <= otg_next;
      ser_reg <= ser_next;
      ser_rx_reg <= ser_rx_next;
      flags_reg <= flags_next;
      hold_reg <= hold_next;
      mask_a_reg <= mask_a_next;
      mask_b_reg <= mask_b_next;
      mask_c_reg <= mask_c_next;
      frame_reg <= frame_next;
      pid_reg <= pid_next;
      ep_reg <= ep_next;
      ep_mask_reg <= ep_mask_next;
      fout_reg <= fout_next;
      armed_reg <= armed_next;
      rxb_reg <= rxb_next;
      rxv_reg <= rxv_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign utmi_opmode_o = func_reg[`UIM_FS_OPMODE_HI:`UIM_FS_OPMODE_LO];
  assign utmi_termselect_o = func_reg[`UIM_FS_TERM];
  assign utmi_xcvrselect_o = func_reg[`UIM_FS_XCVR];
  assign ext_vbus_indicator_mode_o = otg_reg[`UIM_OTG_EXTIND];
  assign drive_vbus_external_mode_o = otg_reg[`UIM_OTG_DRVEXT];
  assign utmi_chrgvbus_o = otg_reg[`UIM_OTG_CHRG];
  assign utmi_dischrgvbus_o = otg_reg[`UIM_OTG_DISCHRG];
  assign utmi_dmpulldown_o = otg_reg[`UIM_OTG_DMPD];
  assign utmi_dppulldown_o = otg_reg[`UIM_OTG_DPPD];
  assign utmi_idpullup_o = otg_reg[`UIM_OTG_IDPU];
  assign utmi_tx_se0_o = ser_reg[`UIM_SER_TXSE0];
  assign utmi_tx_data_o = ser_reg[`UIM_SER_TXDATA];
  assign utmi_tx_enable_n_o = ser_reg[`UIM_SER_TXEN_N];
  assign utmi_fsls_serial_o = ser_reg[`UIM_SER_FSLS];
  assign flag_out_a_o = fout_reg[0];
  assign flag_out_b_o = fout_reg[1];
  assign flag_out_c_o = fout_reg[2];
  assign rx_byte_o = rxb_reg;
  assign rx_byte_valid_o = rxv_reg;
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
endmodule

// >>> uim_phy_model.sv
// behavioural utmi+ transceiver: receive path, line state and status pins
`timescale 1ns/1ns
module uim_phy_model
(
  input wire logic ref_clk_i,
  output logic [1:0] ls_o,
  output logic act_o,
  output logic val_o,
  output logic err_o,
  output logic [7:0] dat_o,
  output logic [8:0] st_o
);
  initial
  begin
    ls_o = 2'h1;
    act_o = 1'b0;
    val_o = 1'b0;
    {err_o, st_o} = 10'h000;
    dat_o = 8'hA5;
  end
  task automatic set(input logic [9:0] v);
    {err_o, st_o} = v;
  endtask
  task automatic line(input logic [1:0] v);
    ls_o = v;
  endtask
  // gap idles the byte stream to act as a slow phy
  task automatic send(input logic [23:0] p, input int n, input int gap);
    @(negedge ref_clk_i);
    act_o = 1'b1;
    @(negedge ref_clk_i);
    for (int i = 0; i < n; i++)
    begin
      val_o = 1'b1;
      dat_o = p[8*i +: 8];
      @(negedge ref_clk_i);
      // valid stays up between back-to-back bytes
      if (gap > 0 || i == n - 1)
      begin
        val_o = 1'b0;
        // stale byte is inverted so nothing can latch it by luck
        dat_o = ~dat_o;
        repeat (gap) @(negedge ref_clk_i);
      end
    end
    act_o = 1'b0;
    repeat (4) @(negedge ref_clk_i);
  endtask
endmodule

// >>> uim_core_properties.sv
// concurrent checks on the usb interface module core ports
`timescale 1ns/1ns
module uim_core_properties
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [2:0] utmi_opmode_o,
  input wire logic utmi_termselect_o,
  input wire logic utmi_xcvrselect_o,
  input wire logic ext_vbus_indicator_mode_o,
  input wire logic utmi_idpullup_o,
  input wire logic utmi_tx_enable_n_o,
  input wire logic utmi_bvalid_i,
  input wire logic utmi_sessend_i
);
  logic [31:0] wd_reg;
  logic [31:0] wd_next;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  always_comb wd_next = reg_wdata_i;
  always_ff @(posedge ref_clk_i)
    wd_reg <= wd_next;
  sequence wr_s(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  sequence rd_s(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  func_write_a: assert property (
    wr_s(8'h0C) |=> {utmi_opmode_o, utmi_termselect_o,
    utmi_xcvrselect_o} == wd_reg[4:0])
    else $error("function select outputs wrong after write");
  func_hold_a: assert property (
    !(reg_wr_i && reg_addr_i == 8'h0C) |=> $stable(utmi_opmode_o))
    else $error("opmode moved without a write");
  otg_write_a: assert property (
    wr_s(8'h10) |=> ext_vbus_indicator_mode_o == wd_reg[7]
    && utmi_idpullup_o == wd_reg[0])
    else $error("otg control outputs wrong after write");
  txen_write_a: assert property (
    wr_s(8'h18) |=> utmi_tx_enable_n_o == wd_reg[1])
    else $error("transmit enable wrong after write");
  status_read_a: assert property (
    rd_s(8'h14) |=> reg_rdata_o[31:6] == 26'h0
    && reg_rdata_o[5] == $past(utmi_bvalid_i)
    && reg_rdata_o[0] == $past(utmi_sessend_i))
    else $error("otg status read wrong");
  pid_read_a: assert property (
    rd_s(8'h2C) |=> reg_rdata_o[31:4] == 28'h0)
    else $error("pid read has upper bits set");
  ep_read_a: assert property (
    rd_s(8'h30) |=> reg_rdata_o[31:5] == 27'h0)
    else $error("endpoint read has upper bits set");
  frame_read_a: assert property (
    rd_s(8'h28) |=> reg_rdata_o[31:11] == 21'h0)
    else $error("frame read has upper bits set");
  reset_value_a: assert property (
    $rose(rst_n_i) |-> utmi_opmode_o == 3'h1 && utmi_termselect_o
    && utmi_xcvrselect_o && utmi_tx_enable_n_o)
    else $error("outputs not at reset values");
endmodule
bind uim_core uim_core_properties uim_core_properties_inst (.*);

// >>> test_uim_core.sv
// self-checking bench for the usb interface module core
`timescale 1ns/1ns
module test_uim_core;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o, d;
  logic reg_rvalid_o, utmi_termselect_o, utmi_xcvrselect_o;
  logic [2:0] utmi_opmode_o;
  logic ext_vbus_indicator_mode_o, drive_vbus_external_mode_o;
  logic utmi_chrgvbus_o, utmi_dischrgvbus_o, utmi_dmpulldown_o;
  logic utmi_dppulldown_o, utmi_idpullup_o, utmi_tx_se0_o;
  logic utmi_tx_data_o, utmi_tx_enable_n_o, utmi_fsls_serial_o;
  logic flag_out_a_o, flag_out_b_o, flag_out_c_o, rx_byte_valid_o;
  logic [7:0] rx_byte_o, last_rx;
  wire [7:0] utmi_data_i;
  wire [1:0] utmi_linestate_i;
  wire utmi_rxactive_i, utmi_rxvalid_i, utmi_rxerror_i;
  wire utmi_bvalid_i, utmi_idgnd_i, utmi_hostdisconnect_i;
  wire utmi_vbusvalid_i, utmi_sessvld_i, utmi_sessend_i;
  wire utmi_rx_rcv_i, utmi_rx_dm_i, utmi_rx_dp_i;
  int err_count = 0;
  int checks_done = 0;
  int rx_cnt = 0;
  int seed = 32'h3F80;
  logic [7:0] ra [12] = '{8'h0C, 8'h10, 8'h18, 8'h1C, 8'h20, 8'h24,
    8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C, 8'h0D};
  logic [31:0] rv [12] = '{32'h7, 32'h0, 32'h2, 32'h8, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] wm [12] = '{32'h1F, 32'hDF, 32'hF, 32'h0, 32'h7F,
    32'h7F7F7F, 32'h7FF, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0};
  uim_core uim_core_inst (.*);
  uim_phy_model phy (.ref_clk_i(ref_clk_i), .ls_o(utmi_linestate_i),
    .act_o(utmi_rxactive_i), .val_o(utmi_rxvalid_i),
    .err_o(utmi_rxerror_i), .dat_o(utmi_data_i),
    .st_o({utmi_rx_rcv_i, utmi_rx_dm_i, utmi_rx_dp_i, utmi_bvalid_i,
    utmi_idgnd_i, utmi_hostdisconnect_i, utmi_vbusvalid_i,
    utmi_sessvld_i, utmi_sessend_i}));
  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
    if (rx_byte_valid_o === 1'b1)
    begin
      last_rx <= rx_byte_o;
      rx_cnt <= rx_cnt + 1;
    end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge ref_clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    @(negedge ref_clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    check({31'h0, reg_rvalid_o}, 32'h1);
    check(reg_rdata_o & m, e);
  endtask
  // crc5 over the 11 token bits; the inverted crc goes out msb first
  function automatic logic [15:0] tok(input logic [10:0] f);
    logic [4:0] c;
    c = 5'h1F;
    for (int i = 0; i < 11; i++)
      c = {c[3:0], 1'b0} ^ ((f[i] ^ c[4]) ? 5'h05 : 5'h00);
    c = ~c;
    return {c[0], c[1], c[2], c[3], c[4], f};
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #(100 * 4000);
    err_count++;
    conclude();
  end
  initial
  begin
    repeat (8) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    foreach (ra[i]) rdx(ra[i], rv[i], 32'hFFFFFFFF);
    foreach (ra[i])
      repeat (3)
      begin
        d = $random(seed);
        wr(ra[i], d);
        rdx(ra[i], (d & wm[i]) | (rv[i] & ~wm[i]), 32'hFFFFFFFF);
      end
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'hFF);
    wr(8'h18, 32'h0);
    check({16'h0, utmi_opmode_o, utmi_termselect_o, utmi_xcvrselect_o,
      ext_vbus_indicator_mode_o, drive_vbus_external_mode_o,
      utmi_chrgvbus_o, utmi_dischrgvbus_o, utmi_dmpulldown_o,
      utmi_dppulldown_o, utmi_idpullup_o, utmi_tx_se0_o, utmi_tx_data_o,
      utmi_tx_enable_n_o, utmi_fsls_serial_o}, 32'h7F0);
    wr(8'h0C, 32'h7);
    wr(8'h18, 32'h2);
    repeat (4)
    begin
      d = $random(seed);
      phy.set(d[9:0]);
      rdx(8'h14, {26'h0, d[5:0]}, 32'hFFFFFFFF);
      rdx(8'h18, {25'h0, d[8:6], 4'h0}, 32'h70);
    end
    phy.set(10'h0);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h41040);
    phy.line(2'h2);
    wr(8'h1C, 32'h7F);
    rdx(8'h1C, 32'h10, 32'h7F);
    check({30'h0, flag_out_b_o, flag_out_a_o}, 32'h2);
    phy.line(2'h0);
    rdx(8'h1C, 32'h30, 32'h7F);
    phy.line(2'h1);
    wr(8'h08, 32'h5);
    wr(8'h34, 32'h8);
    wr(8'h20, 32'h40);
    wr(8'h1C, 32'h7F);
    phy.send({tok({4'h3, 7'h05}), 8'hE1}, 3, 0);
    check({24'h0, last_rx}, 32'h13);
    rdx(8'h30, 32'h13, 32'hFFFFFFFF);
    rdx(8'h2C, 32'h1, 32'hFFFFFFFF);
    rdx(8'h1C, 32'h40, 32'h40);
    check({31'h0, flag_out_a_o}, 32'h1);
    phy.send({tok({4'h3, 7'h06}), 8'hE1}, 3, 2);
    rdx(8'h1C, 32'h40, 32'h40);
    wr(8'h20, 32'h0);
    wr(8'h1C, 32'h7F);
    phy.send({tok({4'h2, 7'h05}), 8'hE1}, 3, 1);
    check({24'h0, last_rx}, 32'h02);
    // zero-length data packet with a good crc, still armed
    phy.send({16'h0000, 8'hC3}, 3, 0);
    check({24'h0, last_rx}, 32'h00);
    rdx(8'h1C, 32'h0, 32'h4);
    phy.send({tok({4'h2, 7'h06}), 8'hE1}, 3, 0);
    rdx(8'h1C, 32'h0, 32'h40);
    phy.send({16'h0100, 8'hC3}, 3, 0);
    rdx(8'h1C, 32'h4, 32'h4);
    check({31'h0, flag_out_c_o}, 32'h1);
    d = $random(seed);
    phy.send({tok(d[10:0]), 8'hA5}, 3, 0);
    rdx(8'h28, {21'h0, d[10:0]}, 32'hFFFFFFFF);
    check(rx_cnt, 32'h4);
    conclude();
  end
endmodule
